// ===== rtl/vtr_regs.svh
`ifndef VTR_REGS_SVH
`define VTR_REGS_SVH

// control word, status word and polarity bit positions
`define VTR_CW_HALT        8
`define VTR_SW_TGT_REACHED 10
`define VTR_SW_LIMIT       11
`define VTR_SW_ZERO_SPEED  12
`define VTR_SW_SLIP        13
`define VTR_POL_VEL_BIT    6

// status word after reset: motor assumed at zero speed
`define VTR_SW_RESET       16'h1000

// timing
`define VTR_CLK_NS         8
`define VTR_TICK_NS        1000000
`define VTR_TICK_CYCLES    ((`VTR_TICK_NS + `VTR_CLK_NS - 1) / `VTR_CLK_NS)
`define VTR_TICKS_PER_S    1000
`define VTR_TICKS_PER_S_SQ 1000000

`endif

// ===== rtl/vtr_pkg.sv
package vtr_pkg;

   typedef enum logic [7:0]
   {
      VTR_MODE_VL = 8'h02,
      VTR_MODE_PV = 8'h03,
      VTR_MODE_PT = 8'h04
   } vtr_mode_t;

   typedef enum logic [15:0]
   {
      VTR_PROF_TRAP = 16'h0000,
      VTR_PROF_JERK = 16'h0003
   } vtr_prof_t;

   typedef enum logic [1:0]
   {
      VTR_ST_IDLE  = 2'b00,
      VTR_ST_RUN   = 2'b01,
      VTR_ST_HALT  = 2'b10,
      VTR_ST_QSTOP = 2'b11
   } vtr_state_t;

endpackage

// ===== rtl/vtr_hold_timer.sv
module vtr_hold_timer
   import vtr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        tick,
   input  wire logic        cond,
   input  wire logic [15:0] limit,
   output logic             hit_q
);

   logic [15:0] cnt_q;

   // condition must hold without a break; any drop restarts the count
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= 16'h0000;
         hit_q <= 1'b0;
      end
      else if (!cond)
      begin
         cnt_q <= 16'h0000;
         hit_q <= 1'b0;
      end
      else if (tick)
      begin
         if (cnt_q >= limit)
            hit_q <= 1'b1;
         else
            cnt_q <= cnt_q + 16'h0001;
      end
   end

endmodule

// ===== rtl/vtr_ramp_ctrl.sv
`include "vtr_regs.svh"
module vtr_ramp_ctrl
   import vtr_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `VTR_TICK_CYCLES
)
(
   input  wire logic               clk,
   input  wire logic               rstn,
   input  wire logic [7:0]         mode_sel,
   input  wire logic [15:0]        ctrl_word,
   input  wire logic               op_enabled,
   input  wire logic               quick_stop,
   input  wire logic               closed_loop,
   input  wire logic signed [31:0] vl_target,
   input  wire logic [31:0]        vl_min,
   input  wire logic [31:0]        vl_max,
   input  wire logic [31:0]        vl_acc_dv,
   input  wire logic [31:0]        vl_acc_dt,
   input  wire logic [31:0]        vl_dec_dv,
   input  wire logic [31:0]        vl_dec_dt,
   input  wire logic [31:0]        vl_qs_dv,
   input  wire logic [31:0]        vl_qs_dt,
   input  wire logic [31:0]        vl_dim_mul,
   input  wire logic [31:0]        vl_dim_div,
   input  wire logic signed [31:0] pv_target,
   input  wire logic [7:0]         pv_polarity,
   input  wire logic [15:0]        pv_prof_type,
   input  wire logic [31:0]        pv_acc,
   input  wire logic [31:0]        pv_dec,
   input  wire logic [31:0]        pv_qs_dec,
   input  wire logic [31:0]        pv_max_acc,
   input  wire logic [31:0]        pv_max_dec,
   input  wire logic [31:0]        pv_jerk1,
   input  wire logic [31:0]        pv_jerk2,
   input  wire logic [31:0]        pv_jerk3,
   input  wire logic [31:0]        pv_jerk4,
   input  wire logic [31:0]        pv_max_prof_vel,
   input  wire logic [31:0]        pv_max_motor_speed,
   input  wire logic [31:0]        pv_vel_window,
   input  wire logic [15:0]        pv_window_time,
   input  wire logic [31:0]        pv_vel_threshold,
   input  wire logic [15:0]        pv_threshold_time,
   input  wire logic [31:0]        max_slippage,
   input  wire logic [15:0]        slip_timeout,
   input  wire logic signed [31:0] actual_vel,
   output logic signed [31:0]      vel_demand_q,
   output logic signed [31:0]      vl_demand_user_q,
   output logic [15:0]             status_word_q,
   output logic [1:0]              ramp_state_q,
   output logic                    pt_running_q
);

   function automatic logic [31:0] mag(input logic signed [31:0] v);
      mag = v[31] ? $unsigned(-v) : $unsigned(v);
   endfunction

   function automatic logic [31:0] umin(input logic [31:0] a, input logic [31:0] b);
      umin = (a < b) ? a : b;
   endfunction

   // saturating v*m/d; a zero divisor saturates rather than faults
   function automatic logic [31:0] scale(input logic [31:0] v, input logic [31:0] m,
                                         input logic [31:0] d);
      logic [63:0] p;
      p = 64'(v) * 64'(m);
      if (d == 32'h0000_0000)
         scale = 32'hFFFF_FFFF;
      else
      begin
         p = p / 64'(d);
         scale = (p[63:32] != 32'h0000_0000) ? 32'hFFFF_FFFF : p[31:0];
      end
   endfunction

   // per-tick step, never below one so the ramp always finishes
   function automatic logic [31:0] per_tick(input logic [31:0] v, input logic [63:0] d);
      logic [63:0] q;
      q = (d == 64'h0) ? 64'(v) : 64'(v) / d;
      per_tick = (q == 64'h0) ? 32'h0000_0001 : q[31:0];
   endfunction

   logic [1:0]  rst_sync_q;
   logic        rst_n_s;
   logic [31:0] tick_cnt_q;
   logic        tick;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rst_sync_q <= 2'b00;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end

   assign rst_n_s = rst_sync_q[1];

   // fixed control tick paces the ramp
   always_ff @(posedge clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
         tick_cnt_q <= 32'h0000_0000;
      else if (tick)
         tick_cnt_q <= 32'h0000_0000;
      else
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
   end

   assign tick = (tick_cnt_q >= 32'(TICK_CYCLES - 1));

   logic        halt;
   logic        halt_q;
   logic        is_vl;
   logic        is_pv;
   logic        is_pt;
   logic        jerk_mode;

   assign halt      = ctrl_word[`VTR_CW_HALT];
   assign is_vl     = (mode_sel == VTR_MODE_VL);
   assign is_pv     = (mode_sel == VTR_MODE_PV);
   assign is_pt     = (mode_sel == VTR_MODE_PT);
   assign jerk_mode = is_pv && (pv_prof_type == VTR_PROF_JERK);

   // plain velocity: scale to internal units then clamp magnitude
   logic [31:0]        vl_mag;
   logic [31:0]        vl_min_i;
   logic [31:0]        vl_max_i;
   logic [31:0]        vl_clamped;
   logic               vl_out_of_range;
   logic signed [31:0] vl_goal;

   always_comb
   begin
      vl_mag   = scale(mag(vl_target), vl_dim_mul, vl_dim_div);
      vl_min_i = scale(vl_min, vl_dim_mul, vl_dim_div);
      vl_max_i = scale(vl_max, vl_dim_mul, vl_dim_div);
      vl_out_of_range = 1'b1;
      if (vl_mag < vl_min_i)
         vl_clamped = vl_min_i;
      else if (vl_mag > vl_max_i)
         vl_clamped = vl_max_i;
      else
      begin
         vl_clamped = vl_mag;
         vl_out_of_range = 1'b0;
      end
      vl_goal = vl_target[31] ? -$signed(vl_clamped) : $signed(vl_clamped);
   end

   // profile velocity goal
   logic [31:0]        pv_cap;
   logic signed [31:0] pv_pol;
   logic signed [31:0] pv_goal;

   always_comb
   begin
      pv_cap = umin(pv_max_prof_vel, pv_max_motor_speed);
      pv_pol = pv_polarity[`VTR_POL_VEL_BIT] ? -pv_target : pv_target;
      if (mag(pv_pol) > pv_cap)
         pv_goal = pv_pol[31] ? -$signed(pv_cap) : $signed(pv_cap);
      else
         pv_goal = pv_pol;
   end

   // ramp rates per tick for the three slopes
   logic [31:0] acc_step;
   logic [31:0] dec_step;
   logic [31:0] qs_step;

   always_comb
   begin
      if (is_vl)
      begin
         // change over seconds, converted to per tick
         acc_step = per_tick(scale(vl_acc_dv, vl_dim_mul, vl_dim_div),
                             64'(vl_acc_dt) * 64'(`VTR_TICKS_PER_S));
         dec_step = per_tick(scale(vl_dec_dv, vl_dim_mul, vl_dim_div),
                             64'(vl_dec_dt) * 64'(`VTR_TICKS_PER_S));
         qs_step  = per_tick(scale(vl_qs_dv, vl_dim_mul, vl_dim_div),
                             64'(vl_qs_dt) * 64'(`VTR_TICKS_PER_S));
      end
      else
      begin
         acc_step = per_tick(umin(pv_acc, pv_max_acc), 64'(`VTR_TICKS_PER_S));
         dec_step = per_tick(umin(pv_dec, pv_max_dec), 64'(`VTR_TICKS_PER_S));
         qs_step  = per_tick(pv_qs_dec, 64'(`VTR_TICKS_PER_S));
      end
   end

   vtr_state_t         state_d;
   logic signed [31:0] goal;
   logic [31:0]        rate;
   logic [31:0]        jerk_up;
   logic [31:0]        jerk_dn;
   logic signed [32:0] err;
   logic [32:0]        err_mag;
   logic               speeding_up;

   always_comb
   begin
      if (!op_enabled || !(is_vl || is_pv || is_pt))
         state_d = VTR_ST_IDLE;
      else if (quick_stop)
         state_d = VTR_ST_QSTOP;
      else if (halt)
         state_d = VTR_ST_HALT;
      else
         state_d = VTR_ST_RUN;
   end

   always_comb
   begin
      err     = {vel_demand_q[31], vel_demand_q};
      err     = {goal[31], goal} - err;
      err_mag = err[32] ? $unsigned(-err) : $unsigned(err);
   end

   always_comb
   begin
      speeding_up = 1'b0;
      case (ramp_state_q)
         VTR_ST_RUN:
         begin
            goal = is_vl ? vl_goal : (is_pv ? pv_goal : actual_vel);
            speeding_up = (vel_demand_q == 32'sh0000_0000) ||
                          ((goal[31] == vel_demand_q[31]) && (mag(goal) > mag(vel_demand_q)));
            rate = speeding_up ? acc_step : dec_step;
         end
         VTR_ST_HALT:
         begin
            goal = 32'sh0000_0000;
            rate = dec_step;
         end
         VTR_ST_QSTOP:
         begin
            goal = 32'sh0000_0000;
            rate = qs_step;
         end
         default:
         begin
            goal = 32'sh0000_0000;
            rate = 32'h0000_0000;
         end
      endcase
      // build-up and taper jerk for acceleration and braking
      jerk_up = per_tick(speeding_up ? pv_jerk1 : pv_jerk3, 64'(`VTR_TICKS_PER_S_SQ));
      jerk_dn = per_tick(speeding_up ? pv_jerk2 : pv_jerk4, 64'(`VTR_TICKS_PER_S_SQ));
   end

   always_ff @(posedge clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
         ramp_state_q <= VTR_ST_IDLE;
      else
         ramp_state_q <= state_d;
   end

   always_ff @(posedge clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
         halt_q <= 1'b0;
      else
         halt_q <= halt;
   end

   // jerk-limited slope: current step grows and tapers by the jerk values;
   // taper distance is an estimate, so the last tick may be short
   logic [31:0] cur_rate_q;
   logic [63:0] taper_dist;

   assign taper_dist = (64'(cur_rate_q) * 64'(cur_rate_q / jerk_dn)) >> 1;

   always_ff @(posedge clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
         cur_rate_q <= 32'h0000_0000;
      else if (!jerk_mode || (halt != halt_q) || (ramp_state_q == VTR_ST_IDLE))
         cur_rate_q <= 32'h0000_0000;
      else if (tick)
      begin
         if ((64'(err_mag) <= taper_dist) && (cur_rate_q > jerk_dn))
            cur_rate_q <= cur_rate_q - jerk_dn;
         else if (cur_rate_q + jerk_up < rate)
            cur_rate_q <= cur_rate_q + jerk_up;
         else
            cur_rate_q <= rate;
      end
   end

   logic [31:0] step;

   assign step = (jerk_mode && (cur_rate_q != 32'h0000_0000)) ? cur_rate_q :
                 (jerk_mode ? umin(jerk_up, rate) : rate);

   // demand moves one step per tick toward the goal, except in idle where it clears to zero and in PT run where it copies actual_vel every cycle
   always_ff @(posedge clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
         vel_demand_q <= 32'sh0000_0000;
      else if (ramp_state_q == VTR_ST_IDLE)
         vel_demand_q <= 32'sh0000_0000;
      else if (is_pt && (ramp_state_q == VTR_ST_RUN))
         vel_demand_q <= actual_vel;
      else if (tick)
      begin
         if (err_mag <= 33'(step))
            vel_demand_q <= goal;
         else if (err[32])
            vel_demand_q <= vel_demand_q - $signed(step);
         else
            vel_demand_q <= vel_demand_q + $signed(step);
      end
   end

   // demand back in user units for the host
   always_ff @(posedge clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
         vl_demand_user_q <= 32'sh0000_0000;
      else if (vel_demand_q[31])
         vl_demand_user_q <= -$signed(scale(mag(vel_demand_q), vl_dim_div, vl_dim_mul));
      else
         vl_demand_user_q <= $signed(scale(mag(vel_demand_q), vl_dim_div, vl_dim_mul));
   end

   always_ff @(posedge clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
         pt_running_q <= 1'b0;
      else
         pt_running_q <= is_pt && (ramp_state_q == VTR_ST_RUN);
   end

   // qualified conditions for the status bits
   logic [31:0] act_mag;
   logic [31:0] dev_mag;
   logic        in_window;
   logic        over_thr;
   logic        slipping;
   logic        win_hit;
   logic        thr_hit;
   logic        slip_hit;

   always_comb
   begin
      act_mag   = mag(actual_vel);
      dev_mag   = mag(actual_vel - vel_demand_q);
      in_window = (dev_mag <= pv_vel_window);
      over_thr  = (act_mag > pv_vel_threshold);
      slipping  = closed_loop && (dev_mag > max_slippage);
   end

   vtr_hold_timer u_win_timer
   (
      .clk   (clk),
      .rst_n (rst_n_s),
      .tick  (tick),
      .cond  (in_window),
      .limit (pv_window_time),
      .hit_q (win_hit)
   );

   vtr_hold_timer u_thr_timer
   (
      .clk   (clk),
      .rst_n (rst_n_s),
      .tick  (tick),
      .cond  (over_thr),
      .limit (pv_threshold_time),
      .hit_q (thr_hit)
   );

   vtr_hold_timer u_slip_timer
   (
      .clk   (clk),
      .rst_n (rst_n_s),
      .tick  (tick),
      .cond  (slipping),
      .limit (slip_timeout),
      .hit_q (slip_hit)
   );

   // status word; bits not owned here read as zero
   logic [15:0] sw_d;

   always_comb
   begin
      sw_d = 16'h0000;
      sw_d[`VTR_SW_ZERO_SPEED] = !thr_hit;
      sw_d[`VTR_SW_SLIP]       = slip_hit;
      if (is_vl)
         // clamped target or ramp still limiting
         sw_d[`VTR_SW_LIMIT] = vl_out_of_range || (vel_demand_q != vl_goal);
      if (is_pv)
      begin
         if (halt)
            sw_d[`VTR_SW_TGT_REACHED] = !thr_hit && (vel_demand_q == 32'sh0000_0000);
         else
            sw_d[`VTR_SW_TGT_REACHED] = win_hit;
      end
   end

   always_ff @(posedge clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
         status_word_q <= `VTR_SW_RESET;
      else
         status_word_q <= sw_d;
   end

endmodule

// ===== sim/vtr_ramp_chk.sv
module vtr_ramp_chk
#(
   parameter int unsigned TICK_CYCLES = 10
)
(
   input wire logic               clk,
   input wire logic               rstn,
   input wire logic [7:0]         mode_sel,
   input wire logic [15:0]        ctrl_word,
   input wire logic               op_enabled,
   input wire logic               quick_stop,
   input wire logic               closed_loop,
   input wire logic signed [31:0] actual_vel,
   input wire logic signed [31:0] vel_demand_q,
   input wire logic [15:0]        status_word_q,
   input wire logic [1:0]         ramp_state_q,
   input wire logic               pt_running_q
);
   logic [1:0]         rel_q;
   logic [15:0]        gap_q;
   logic signed [31:0] prev_q;
   logic               stay_q;
   logic               live;
   logic               up;
   logic               mode_ok;
   logic               steady;
   logic               chg;

   // internal reset copy lags rstn by two edges, so state checks wait
   assign up      = (rel_q == 2'h3);
   assign mode_ok = op_enabled && (mode_sel inside {8'h02, 8'h03, 8'h04});
   assign steady  = op_enabled && (mode_sel inside {8'h02, 8'h03}) && (ramp_state_q != 2'h0);
   assign chg     = (vel_demand_q != prev_q);
   // idle zeroing is no tick step: only judge after a full cycle in a ramp state
   assign live    = steady && stay_q;

   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
         rel_q <= 2'h0;
      else if (!up)
         rel_q <= rel_q + 2'h1;

   // gap since the last demand step; saturated outside ramp modes so the first tick passes
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
      begin
         gap_q  <= 16'hFFFF;
         prev_q <= 32'sh0;
         stay_q <= 1'b0;
      end
      else
      begin
         prev_q <= vel_demand_q;
         stay_q <= steady;
         if (!live)
            gap_q <= 16'hFFFF;
         else if (chg)
            gap_q <= 16'h0;
         else if (gap_q != 16'hFFFF)
            gap_q <= gap_q + 16'h1;
      end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   idle_state_a: assert property (!op_enabled |=> ramp_state_q == 2'h0)
      else $error("ramp not idle without enable");
   qstop_state_a: assert property (up && mode_ok && quick_stop |=> ramp_state_q == 2'h3)
      else $error("quick stop state missed");
   halt_state_a: assert property (up && mode_ok && !quick_stop && ctrl_word[8] |=> ramp_state_q == 2'h2)
      else $error("halt state missed");
   run_state_a: assert property (up && mode_ok && !quick_stop && !ctrl_word[8] |=> ramp_state_q == 2'h1)
      else $error("run state missed");
   idle_zero_a: assert property (!op_enabled ##1 !op_enabled |=> vel_demand_q == 32'sh0)
      else $error("demand not zero while disabled");
   tick_step_a: assert property (chg && live |-> gap_q >= TICK_CYCLES - 1)
      else $error("demand moved between ticks");
   limit_mode_a: assert property ((mode_sel != 8'h02) [*2] |=> !status_word_q[11])
      else $error("limit flag outside velocity mode");
   reach_mode_a: assert property ((mode_sel != 8'h03) [*2] |=> !status_word_q[10])
      else $error("reached flag outside profile mode");
   zero_speed_a: assert property (actual_vel == 32'sh0 |-> ##2 status_word_q[12])
      else $error("zero speed flag low at standstill");
   slip_open_a: assert property (!closed_loop |-> ##2 !status_word_q[13])
      else $error("slip flag in open loop");
   pt_halt_a: assert property (up && op_enabled && mode_sel == 8'h04 && !quick_stop && ctrl_word[8]
                               |-> ##2 !pt_running_q)
      else $error("torque run flag while halted");
endmodule

bind vtr_ramp_ctrl vtr_ramp_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk
(
   .clk(clk), .rstn(rstn), .mode_sel(mode_sel), .ctrl_word(ctrl_word),
   .op_enabled(op_enabled), .quick_stop(quick_stop), .closed_loop(closed_loop),
   .actual_vel(actual_vel), .vel_demand_q(vel_demand_q), .status_word_q(status_word_q),
   .ramp_state_q(ramp_state_q), .pt_running_q(pt_running_q)
);

// ===== sim/vtr_motor_model.sv
module vtr_motor_model
(
   input wire logic               clk,
   input wire logic               rstn,
   input wire logic signed [31:0] demand,
   input wire logic               slow,
   input wire logic signed [31:0] slip_off,
   output logic signed [31:0]     actual_q
);
   timeunit 1ns;
   timeprecision 1ps;
   // slow mode closes a quarter of the gap, stalls within 3 units of the set point
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
         actual_q <= 32'sh0;
      else if (slow)
         actual_q <= actual_q + ((demand + slip_off - actual_q) >>> 2);
      else
         actual_q <= demand + slip_off;
endmodule

// ===== sim/tb_vtr_ramp_ctrl.sv
`include "vtr_regs.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
`define WAIT(c, n) for (int k = 0; k < (n) && !(c); k++) @(negedge clk);

module tb_vtr_ramp_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TC = 10;
   logic                    clk = 1'b0, rstn = 1'b0, op_enabled = 1'b0;
   logic                    quick_stop = 1'b0, closed_loop = 1'b0, slow = 1'b0;
   logic [7:0]              mode_sel = 8'h00, pv_polarity = 8'h00;
   logic [15:0]             ctrl_word = 16'h0, pv_prof_type = 16'h0, pv_window_time = 16'h3;
   logic [15:0]             pv_threshold_time = 16'h2, slip_timeout = 16'h2;
   logic signed [31:0]      vl_target = 32'sh0, pv_target = 32'sh0, slip_off = 32'sh0;
   logic [31:0]             vl_min = 32'h0, vl_max = 32'h3E8, vl_acc_dv = 32'h3E8, vl_acc_dt = 32'h1;
   logic [31:0]             vl_dec_dv = 32'h7D0, vl_dec_dt = 32'h1, vl_qs_dv = 32'h186A0;
   logic [31:0]             vl_qs_dt = 32'h1, vl_dim_mul = 32'h1, vl_dim_div = 32'h1;
   logic [31:0]             pv_acc = 32'h186A0, pv_dec = 32'h186A0, pv_qs_dec = 32'h186A0;
   logic [31:0]             pv_max_acc = 32'h186A0, pv_max_dec = 32'h186A0, pv_jerk = 32'h02FAF080;
   logic [31:0]             pv_max_prof_vel = 32'h7D0, pv_max_motor_speed = 32'h1388;
   logic [31:0]             pv_vel_window = 32'h5, pv_vel_threshold = 32'hA, max_slippage = 32'h32;
   logic signed [31:0]      actual_vel, vel_demand_q, vl_demand_user_q;
   logic [15:0]             status_word_q;
   logic [1:0]              ramp_state_q;
   logic                    pt_running_q;
   int                      n_fail = 0, checks_done = 0;

   always #4 clk = ~clk;

   vtr_ramp_ctrl #(.TICK_CYCLES(TC)) dut
   (
      .clk(clk), .rstn(rstn), .mode_sel(mode_sel), .ctrl_word(ctrl_word), .op_enabled(op_enabled),
      .quick_stop(quick_stop), .closed_loop(closed_loop), .vl_target(vl_target), .vl_min(vl_min),
      .vl_max(vl_max), .vl_acc_dv(vl_acc_dv), .vl_acc_dt(vl_acc_dt), .vl_dec_dv(vl_dec_dv),
      .vl_dec_dt(vl_dec_dt), .vl_qs_dv(vl_qs_dv), .vl_qs_dt(vl_qs_dt), .vl_dim_mul(vl_dim_mul),
      .vl_dim_div(vl_dim_div), .pv_target(pv_target), .pv_polarity(pv_polarity),
      .pv_prof_type(pv_prof_type), .pv_acc(pv_acc), .pv_dec(pv_dec), .pv_qs_dec(pv_qs_dec),
      .pv_max_acc(pv_max_acc), .pv_max_dec(pv_max_dec), .pv_jerk1(pv_jerk), .pv_jerk2(pv_jerk),
      .pv_jerk3(pv_jerk), .pv_jerk4(pv_jerk), .pv_max_prof_vel(pv_max_prof_vel),
      .pv_max_motor_speed(pv_max_motor_speed), .pv_vel_window(pv_vel_window),
      .pv_window_time(pv_window_time), .pv_vel_threshold(pv_vel_threshold),
      .pv_threshold_time(pv_threshold_time), .max_slippage(max_slippage),
      .slip_timeout(slip_timeout), .actual_vel(actual_vel), .vel_demand_q(vel_demand_q),
      .vl_demand_user_q(vl_demand_user_q), .status_word_q(status_word_q),
      .ramp_state_q(ramp_state_q), .pt_running_q(pt_running_q)
   );

   vtr_motor_model u_motor
   (
      .clk(clk), .rstn(rstn), .demand(vel_demand_q), .slow(slow), .slip_off(slip_off),
      .actual_q(actual_vel)
   );

   task automatic go(input logic [7:0] m, input logic h);
      @(negedge clk);
      mode_sel = m;
      ctrl_word[`VTR_CW_HALT] = h;
      repeat (2) @(negedge clk);
   endtask

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // expected run is under 10k cycles; ten times that means a hang
   initial
   begin
      repeat (100000) @(posedge clk);
      n_fail++;
      stop_test;
   end

   initial
   begin
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      `CHK(status_word_q, `VTR_SW_RESET)
      `CHK(vel_demand_q, 32'sh0)
      repeat (3) @(negedge clk);
      op_enabled = 1'b1;
      vl_target = 32'sh14;
      go(8'h02, 1'b0);
      `CHK(ramp_state_q, vtr_pkg::VTR_ST_RUN)
      `WAIT(vel_demand_q == 32'sh0A, 40 * TC)
      @(negedge clk);
      `CHK(status_word_q[`VTR_SW_LIMIT], 1'b1)
      repeat (TC - 1) @(negedge clk);
      `CHK(vel_demand_q, 32'sh0B)
      `WAIT(vel_demand_q == 32'sh14, 40 * TC)
      repeat (2) @(negedge clk);
      `CHK(status_word_q[`VTR_SW_LIMIT], 1'b0)
      `CHK(vl_demand_user_q, 32'sh14)
      go(8'h02, 1'b1);
      `CHK(ramp_state_q, vtr_pkg::VTR_ST_HALT)
      `WAIT(vel_demand_q != 32'sh14, 2 * TC)
      `CHK(vel_demand_q, 32'sh12)
      `WAIT(vel_demand_q == 32'sh0, 20 * TC)
      `CHK(vel_demand_q, 32'sh0)
      go(8'h02, 1'b0);
      `WAIT(vel_demand_q == 32'sh14, 40 * TC)
      `CHK(vel_demand_q, 32'sh14)
      // factor 60/2 turns user units into 30 internal units each
      vl_dim_mul = 32'h3C;
      vl_dim_div = 32'h2;
      vl_acc_dv = 32'h186A0;
      vl_dec_dv = 32'h186A0;
      vl_min = 32'h5;
      vl_target = 32'sh2328;
      `WAIT(vl_demand_user_q == 32'sh3E8, 800 * TC)
      `CHK(vel_demand_q, 32'sh7530)
      `CHK(status_word_q[`VTR_SW_LIMIT], 1'b1)
      vl_target = 32'sh2;
      `WAIT(vl_demand_user_q == 32'sh5, 800 * TC)
      `CHK(vel_demand_q, 32'sh96)
      vl_qs_dt = 32'h2;
      quick_stop = 1'b1;
      repeat (2) @(negedge clk);
      `CHK(ramp_state_q, vtr_pkg::VTR_ST_QSTOP)
      `WAIT(vel_demand_q == 32'sh0, 200 * TC)
      `CHK(vel_demand_q, 32'sh0)
      quick_stop = 1'b0;
      slow = 1'b1;
      pv_target = 32'sh12C;
      go(8'h03, 1'b0);
      `CHK(status_word_q[`VTR_SW_TGT_REACHED], 1'b0)
      `WAIT(vel_demand_q == 32'sh12C, 60 * TC)
      `CHK(status_word_q[`VTR_SW_TGT_REACHED], 1'b0)
      `WAIT(status_word_q[`VTR_SW_TGT_REACHED] === 1'b1, 60 * TC)
      `CHK(status_word_q[`VTR_SW_TGT_REACHED], 1'b1)
      `CHK(status_word_q[`VTR_SW_ZERO_SPEED], 1'b0)
      pv_dec = 32'h30D40;
      go(8'h03, 1'b1);
      `CHK(status_word_q[`VTR_SW_TGT_REACHED], 1'b0)
      `WAIT(status_word_q[`VTR_SW_TGT_REACHED] === 1'b1, 100 * TC)
      `CHK(vel_demand_q, 32'sh0)
      `CHK(status_word_q[`VTR_SW_ZERO_SPEED], 1'b1)
      pv_polarity = 8'h40;
      go(8'h03, 1'b0);
      `WAIT(vel_demand_q == -32'sh12C, 60 * TC)
      `CHK(vel_demand_q, -32'sh12C)
      pv_polarity = 8'h00;
      pv_target = 32'sh2328;
      `WAIT(vel_demand_q == 32'sh7D0, 200 * TC)
      `CHK(vel_demand_q, 32'sh7D0)
      pv_prof_type = 16'h3;
      pv_target = 32'sh12C;
      // jerk of 50 per tick caps the first step at half of the 100 slope (pv_dec capped by pv_max_dec)
      `WAIT(vel_demand_q != 32'sh7D0, 2 * TC)
      `CHK(vel_demand_q, 32'sh79E)
      `WAIT(vel_demand_q == 32'sh12C, 300 * TC)
      `CHK(vel_demand_q, 32'sh12C)
      pv_prof_type = 16'h0;
      slow = 1'b0;
      slip_off = 32'shC8;
      repeat (10 * TC) @(negedge clk);
      `CHK(status_word_q[`VTR_SW_SLIP], 1'b0)
      closed_loop = 1'b1;
      `WAIT(status_word_q[`VTR_SW_SLIP] === 1'b1, 60 * TC)
      `CHK(status_word_q[`VTR_SW_SLIP], 1'b1)
      closed_loop = 1'b0;
      slip_off = 32'sh0;
      repeat (2) @(negedge clk);
      `CHK(status_word_q[`VTR_SW_SLIP], 1'b0)
      go(8'h04, 1'b0);
      `CHK(pt_running_q, 1'b1)
      `CHK(vel_demand_q, actual_vel)
      go(8'h04, 1'b1);
      `CHK(pt_running_q, 1'b0)
      `WAIT(vel_demand_q == 32'sh0, 100 * TC)
      `CHK(vel_demand_q, 32'sh0)
      go(8'h07, 1'b0);
      `CHK(ramp_state_q, vtr_pkg::VTR_ST_IDLE)
      go(8'h03, 1'b0);
      op_enabled = 1'b0;
      repeat (3) @(negedge clk);
      `CHK(vel_demand_q, 32'sh0)
      stop_test;
   end
endmodule
